// ==== core/usb_ep_regs.svh ====
`ifndef USB_EP_REGS_SVH
`define USB_EP_REGS_SVH

// endpoint count and register map, one mode and one count word per endpoint
`define NUM_EP          3
`define REG_MODE_OFS    8'h00
`define REG_COUNT_OFS   8'h04
`define EP_STRIDE       8'h08

// mode register fields
`define MODE_LSB        0
`define MODE_MSB        3
`define MODE_ACK_BIT    4
`define MODE_OUT_BIT    5
`define MODE_IN_BIT     6
`define MODE_SETUP_BIT  7

// count register fields
`define CNT_LSB         0
`define CNT_MSB         3
`define CNT_DVAL_BIT    6
`define CNT_TOG_BIT     7

// reset values
`define MODE_RESET      4'h0
`define CNT_RESET       4'h0

// packet limits: 8-byte payload plus 2 crc bytes, zero-length packet is crc only
`define EP_SIZE_BYTES   5'h08
`define CRC_BYTES       5'h02
`define MAX_PKT_BYTES   (`EP_SIZE_BYTES + `CRC_BYTES)
`define ZLP_BYTES       5'h02

`endif

// ==== core/usb_ep_pkg.sv ====
package usb_ep_pkg;

  // endpoint modes, written by firmware into the low nibble of the mode register
  typedef enum logic [3:0] {
    MODE_DISABLED          = 4'b0000,
    MODE_NAK_IN_OUT        = 4'b0001,
    MODE_STATUS_OUT_ONLY   = 4'b0010,
    MODE_STALL_IN_OUT      = 4'b0011,
    MODE_IGNORE_IN_OUT     = 4'b0100,
    MODE_ISO_OUT           = 4'b0101,
    MODE_STATUS_IN_ONLY    = 4'b0110,
    MODE_ISO_IN            = 4'b0111,
    MODE_NAK_OUT           = 4'b1000,
    MODE_ACK_OUT           = 4'b1001,
    MODE_NAK_OUT_STATUS_IN = 4'b1010,
    MODE_ACK_OUT_STATUS_IN = 4'b1011,
    MODE_NAK_IN            = 4'b1100,
    MODE_ACK_IN            = 4'b1101,
    MODE_NAK_IN_STATUS_OUT = 4'b1110,
    MODE_ACK_IN_STATUS_OUT = 4'b1111
  } ep_mode_t;

  typedef enum logic [1:0] {
    PID_OUT   = 2'b00,
    PID_IN    = 2'b01,
    PID_SETUP = 2'b10,
    PID_NONE  = 2'b11
  } pid_t;

  // answer handed to the serial_interface_engine
  typedef enum logic [2:0] {
    RESP_IGNORE   = 3'b000,
    RESP_ACK      = 3'b001,
    RESP_NAK      = 3'b010,
    RESP_STALL    = 3'b011,
    RESP_TX_COUNT = 3'b100,
    RESP_TX_ZERO  = 3'b101,
    RESP_SILENT   = 3'b110
  } resp_t;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_DATA      = 2'b01,
    ST_IN_DECIDE = 2'b10,
    ST_HANDSHAKE = 2'b11
  } xact_state_t;

  // modes that answer a setup token
  function automatic logic mode_accepts_setup(input logic [3:0] m);
    case (m)
      4'b0001, 4'b0010, 4'b0011, 4'b0100, 4'b0110,
      4'b1010, 4'b1011, 4'b1110, 4'b1111: mode_accepts_setup = 1'b1;
      default:                            mode_accepts_setup = 1'b0;
    endcase
  endfunction

  // ack modes fall back to their nak twin; others keep their mode
  function automatic logic [3:0] mode_after_ack(input logic [3:0] m);
    case (m)
      4'b1001: mode_after_ack = 4'b1000;
      4'b1011: mode_after_ack = 4'b1010;
      4'b1101: mode_after_ack = 4'b1100;
      4'b1111: mode_after_ack = 4'b1110;
      default: mode_after_ack = m;
    endcase
  endfunction

endpackage

// ==== core/ep_response_decode.sv ====
`timescale 1ns/1ns
module ep_response_decode
  import usb_ep_pkg::*;
(
  input  wire logic [3:0] mode,
  input  wire pid_t       pid,
  input  wire logic       zlp_toggle_one,
  output resp_t           resp,
  output logic            takes_data
);

  // per-mode answer to in and out tokens; setup is handled by the caller
  always_comb begin
    resp       = RESP_IGNORE;
    takes_data = 1'b0;
    case (pid)
      PID_IN: begin
        case (mode)
          4'b0001, 4'b1100, 4'b1110:          resp = RESP_NAK;
          4'b0010, 4'b0011:                   resp = RESP_STALL;
          4'b0110, 4'b1010, 4'b1011:          resp = RESP_TX_ZERO;
          4'b0111, 4'b1101, 4'b1111:          resp = RESP_TX_COUNT;
          default:                            resp = RESP_IGNORE;
        endcase
      end
      PID_OUT: begin
        case (mode)
          4'b0001, 4'b1000, 4'b1010:          resp = RESP_NAK;
          4'b0011, 4'b0110:                   resp = RESP_STALL;
          4'b0101: begin
            resp       = RESP_SILENT;
            takes_data = 1'b1;
          end
          4'b1001, 4'b1011: begin
            resp       = RESP_ACK;
            takes_data = 1'b1;
          end
          // status check: zero-length with toggle one, else stall
          4'b0010, 4'b1110, 4'b1111:
            resp = zlp_toggle_one ? RESP_ACK : RESP_STALL;
          default:                            resp = RESP_IGNORE;
        endcase
      end
      default: resp = RESP_IGNORE;
    endcase
  end

endmodule // ep_response_decode

// ==== core/ep0_write_lock.sv ====
`timescale 1ns/1ns
module ep0_write_lock (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic lock_set,
  input  wire logic cpu_read,
  output logic      locked
);

  // a new ack wins over a read in the same cycle so no update goes unseen
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      locked <= 1'b0;
    end else if (lock_set) begin
      locked <= 1'b1;
    end else if (cpu_read) begin
      locked <= 1'b0;
    end
  end

endmodule // ep0_write_lock

// ==== core/usb_endpoint_mode_responder.sv ====
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "usb_ep_regs.svh"

module usb_endpoint_mode_responder
  import usb_ep_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // apb register port
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // token and data events from the serial_interface_engine
  input  wire logic        tok_valid,
  input  wire pid_t        tok_pid,
  input  wire logic [1:0]  tok_ep,
  input  wire logic        data_start,
  input  wire logic        data_end,
  input  wire logic [4:0]  data_count,
  input  wire logic        data_toggle,
  input  wire logic        data_crc_ok,
  input  wire logic        data_checks_ok,
  input  wire logic        hs_valid,
  input  wire logic        hs_ack,
  // answer to the serial_interface_engine
  output logic             resp_valid,
  output resp_t            resp_code,
  output logic [3:0]       tx_len,
  output logic [2:0]       ep_irq
);

  // endpoint state
  logic [3:0]  mode      [0:`NUM_EP-1];
  logic [3:0]  cnt       [0:`NUM_EP-1];
  logic [`NUM_EP-1:0] ack_bit;
  logic [`NUM_EP-1:0] in_bit;
  logic [`NUM_EP-1:0] out_bit;
  logic [`NUM_EP-1:0] setup_bit;
  logic [`NUM_EP-1:0] dval;
  logic [`NUM_EP-1:0] data_toggle_bit;

  logic [3:0]  next_mode [0:`NUM_EP-1];
  logic [3:0]  next_cnt  [0:`NUM_EP-1];
  logic [`NUM_EP-1:0] next_ack_bit;
  logic [`NUM_EP-1:0] next_in_bit;
  logic [`NUM_EP-1:0] next_out_bit;
  logic [`NUM_EP-1:0] next_setup_bit;
  logic [`NUM_EP-1:0] next_dval;
  logic [`NUM_EP-1:0] next_data_toggle_bit;

  // transaction tracking
  xact_state_t state;
  xact_state_t next_state;
  logic [1:0]  cur_ep;
  pid_t        cur_pid;

  // apb decode
  wire logic [1:0] addr_ep       = paddr[4:3];
  wire logic       addr_is_count = paddr[2];
  wire logic       addr_hit      = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0)
                                   && (addr_ep < 2'(`NUM_EP));
  wire logic       apb_start     = psel && penable && !pready;
  wire logic       apb_done      = psel && penable && pready;
  wire logic       fw_wr         = apb_done && pwrite && addr_hit;
  wire logic       fw_rd         = apb_done && !pwrite && addr_hit;
  wire logic       fw_wr_mode    = fw_wr && !addr_is_count;
  wire logic       fw_wr_cnt     = fw_wr && addr_is_count;
  wire logic       rd_ep0_mode   = fw_rd && (addr_ep == 2'h0) && !addr_is_count;
  wire logic       rd_ep0_cnt    = fw_rd && (addr_ep == 2'h0) && addr_is_count;

  // packet qualification
  wire logic [3:0] cur_mode      = mode[cur_ep];
  wire logic       data_valid    = data_crc_ok && data_checks_ok
                                   && (data_count <= `MAX_PKT_BYTES);
  wire logic       zlp_tog_one   = (data_count == `ZLP_BYTES) && data_toggle;
  wire logic       accepts_setup = mode_accepts_setup(cur_mode);
  wire logic       is_setup      = (cur_pid == PID_SETUP);
  wire logic       fin_data      = (state == ST_DATA) && data_end;
  wire logic       fin_in        = (state == ST_IN_DECIDE);
  wire logic       fin_hs        = (state == ST_HANDSHAKE) && hs_valid;
  wire logic       setup_start   = (state == ST_DATA) && data_start
                                   && is_setup && accepts_setup;

  resp_t      dec_resp;
  logic       dec_takes_data;

  ep_response_decode u_decode (
    .mode           (cur_mode),
    .pid            (cur_pid),
    .zlp_toggle_one (zlp_tog_one),
    .resp           (dec_resp),
    .takes_data     (dec_takes_data)
  );

  // hardware update request for the current endpoint
  resp_t      hw_resp;
  logic       hw_mode_we;
  logic [3:0] hw_mode;
  logic       hw_cnt_we;
  logic       hw_dval;
  logic       hw_set_ack;
  logic       hw_set_in;
  logic       hw_set_out;
  logic       hw_irq;
  logic       hw_lock;

  // transaction outcome; invalid packets never get a handshake
  always_comb begin
    hw_resp    = RESP_IGNORE;
    hw_mode_we = 1'b0;
    hw_mode    = cur_mode;
    hw_cnt_we  = 1'b0;
    hw_dval    = 1'b0;
    hw_set_ack = 1'b0;
    hw_set_in  = 1'b0;
    hw_set_out = 1'b0;
    hw_irq     = 1'b0;
    if (fin_data && is_setup && accepts_setup) begin
      hw_cnt_we = 1'b1;
      hw_dval   = data_valid;
      hw_irq    = 1'b1;
      if (data_valid) begin
        hw_resp    = RESP_ACK;
        hw_set_ack = 1'b1;
        hw_mode_we = 1'b1;
        hw_mode    = MODE_NAK_IN_OUT;
      end
    end else if (fin_data && !is_setup) begin
      if (data_valid) begin
        hw_resp    = dec_resp;
        hw_set_out = (dec_resp != RESP_IGNORE);
        hw_irq     = (dec_resp != RESP_IGNORE);
        if (dec_takes_data) begin
          hw_cnt_we = 1'b1;
          hw_dval   = 1'b1;
        end
        if (dec_resp == RESP_ACK) begin
          hw_set_ack = 1'b1;
          hw_mode_we = 1'b1;
          hw_mode    = mode_after_ack(cur_mode);
        end
      end else if (dec_takes_data && !data_crc_ok) begin
        // buffer was already written, so flag it and tell firmware
        hw_cnt_we = 1'b1;
        hw_dval   = 1'b0;
        hw_irq    = 1'b1;
      end
    end else if (fin_in) begin
      hw_resp = dec_resp;
      if ((dec_resp == RESP_NAK) || (dec_resp == RESP_STALL)) begin
        hw_set_in = 1'b1;
        hw_irq    = 1'b1;
      end
    end else if (fin_hs && hs_ack) begin
      hw_set_in  = 1'b1;
      hw_set_ack = 1'b1;
      hw_irq     = 1'b1;
      hw_mode_we = 1'b1;
      hw_mode    = mode_after_ack(cur_mode);
    end
  end

  // ack exchanged on endpoint 0 locks both registers, all but the mode register's setup bit
  assign hw_lock = hw_set_ack && (cur_ep == 2'h0);

  logic mode_locked;
  logic cnt_locked;

  ep0_write_lock u_mode_lock (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .lock_set (hw_lock),
    .cpu_read (rd_ep0_mode),
    .locked   (mode_locked)
  );

  ep0_write_lock u_cnt_lock (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .lock_set (hw_lock),
    .cpu_read (rd_ep0_cnt),
    .locked   (cnt_locked)
  );

  // next register values; hardware wins over a firmware write in the same cycle
  always_comb begin
    for (int i = 0; i < `NUM_EP; i++) begin
      logic sel;
      logic wr_m;
      logic wr_c;
      sel  = (cur_ep == 2'(i));
      wr_m = fw_wr_mode && (addr_ep == 2'(i)) && !((i == 0) && mode_locked);
      wr_c = fw_wr_cnt && (addr_ep == 2'(i)) && !((i == 0) && cnt_locked);
      next_mode[i]            = mode[i];
      next_ack_bit[i]         = ack_bit[i];
      next_in_bit[i]          = in_bit[i];
      next_out_bit[i]         = out_bit[i];
      next_setup_bit[i]       = setup_bit[i];
      next_cnt[i]             = cnt[i];
      next_dval[i]            = dval[i];
      next_data_toggle_bit[i] = data_toggle_bit[i];
      if (wr_m) begin
        next_mode[i]    = pwdata[`MODE_MSB:`MODE_LSB];
        next_ack_bit[i] = pwdata[`MODE_ACK_BIT];
        next_in_bit[i]  = pwdata[`MODE_IN_BIT];
        next_out_bit[i] = pwdata[`MODE_OUT_BIT];
      end
      if (fw_wr_mode && (addr_ep == 2'(i))) begin
        next_setup_bit[i] = pwdata[`MODE_SETUP_BIT];
      end
      if (wr_c) begin
        next_cnt[i]             = pwdata[`CNT_MSB:`CNT_LSB];
        next_dval[i]            = pwdata[`CNT_DVAL_BIT];
        next_data_toggle_bit[i] = pwdata[`CNT_TOG_BIT];
      end
      if (sel && hw_mode_we) begin
        next_mode[i] = hw_mode;
      end
      if (sel && hw_set_ack) begin
        next_ack_bit[i] = 1'b1;
      end
      if (sel && hw_set_in) begin
        next_in_bit[i] = 1'b1;
      end
      if (sel && hw_set_out) begin
        next_out_bit[i] = 1'b1;
      end
      if (sel && setup_start) begin
        next_setup_bit[i] = 1'b1;
      end
      if (sel && hw_cnt_we) begin
        next_cnt[i]             = data_count[3:0];
        next_dval[i]            = hw_dval;
        next_data_toggle_bit[i] = data_toggle;
      end
    end
  end

  // endpoint registers; everything disabled out of reset
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `NUM_EP; i++) begin
      if (!rst_n) begin
        mode[i] <= `MODE_RESET;
        cnt[i]  <= `CNT_RESET;
      end else begin
        mode[i] <= next_mode[i];
        cnt[i]  <= next_cnt[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_bit         <= '0;
      in_bit          <= '0;
      out_bit         <= '0;
      setup_bit       <= '0;
      dval            <= '0;
      data_toggle_bit <= '0;
    end else begin
      ack_bit         <= next_ack_bit;
      in_bit          <= next_in_bit;
      out_bit         <= next_out_bit;
      setup_bit       <= next_setup_bit;
      dval            <= next_dval;
      data_toggle_bit <= next_data_toggle_bit;
    end
  end

  // transaction sequencing; a token to a missing endpoint is not ours
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (tok_valid && (tok_ep < 2'(`NUM_EP))) begin
          next_state = (tok_pid == PID_IN) ? ST_IN_DECIDE : ST_DATA;
        end
      end
      ST_DATA: begin
        if (data_end) begin
          next_state = ST_IDLE;
        end
      end
      ST_IN_DECIDE: begin
        if ((dec_resp == RESP_TX_COUNT) || (dec_resp == RESP_TX_ZERO)) begin
          next_state = ST_HANDSHAKE;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_HANDSHAKE: begin
        if (hs_valid) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      cur_ep  <= 2'h0;
      cur_pid <= PID_NONE;
    end else begin
      state <= next_state;
      if ((state == ST_IDLE) && tok_valid) begin
        cur_ep  <= tok_ep;
        cur_pid <= tok_pid;
      end
    end
  end

  // answer and interrupt pulses; silent iso accepts give no handshake
  wire logic  send_resp = (hw_resp != RESP_IGNORE) && (hw_resp != RESP_SILENT);
  wire logic [2:0] irq_vec = hw_irq ? (3'h1 << cur_ep) : 3'h0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_code  <= RESP_IGNORE;
      tx_len     <= 4'h0;
      ep_irq     <= 3'h0;
    end else begin
      resp_valid <= send_resp;
      resp_code  <= hw_resp;
      tx_len     <= (hw_resp == RESP_TX_COUNT) ? cnt[cur_ep] : 4'h0;
      ep_irq     <= irq_vec;
    end
  end

  // apb read view of the addressed register
  wire logic [31:0] rd_mode_word = {24'h0, setup_bit[addr_ep], in_bit[addr_ep],
                                    out_bit[addr_ep], ack_bit[addr_ep], mode[addr_ep]};
  wire logic [31:0] rd_cnt_word  = {24'h0, data_toggle_bit[addr_ep], dval[addr_ep],
                                    2'h0, cnt[addr_ep]};
  wire logic [31:0] rd_word      = !addr_hit ? 32'h0 :
                                   (addr_is_count ? rd_cnt_word : rd_mode_word);

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_start;
      pslverr <= apb_start && !addr_hit;
      prdata  <= (apb_start && !pwrite) ? rd_word : 32'h0;
    end
  end

endmodule // usb_endpoint_mode_responder

// ==== bench/ep_props.sv ====
`timescale 1ns/1ns
module ep_props
  import usb_ep_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       tok_valid,
  input wire pid_t       tok_pid,
  input wire logic [1:0] tok_ep,
  input wire logic       data_end,
  input wire logic [4:0] data_count,
  input wire logic       data_checks_ok,
  input wire logic       hs_valid,
  input wire logic       resp_valid,
  input wire resp_t      resp_code,
  input wire logic [3:0] tx_len,
  input wire logic [2:0] ep_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [1:0] cur_ep;
  // endpoint of the token in flight, so irq routing can be judged
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      cur_ep <= 2'h0;
    else if (tok_valid)
      cur_ep <= tok_ep;
  end
  sequence acc_first;
    psel && penable && !$past(penable);
  endsequence
  sequence one_wait;
    !pready ##1 pready;
  endsequence
  chk_apb_wait: assert property (acc_first |-> one_wait)
    else $error("apb answer not after one wait state");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  chk_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("answer longer than one cycle");
  chk_resp_cause: assert property (resp_valid |-> $past(data_end) ||
      ($past(tok_valid, 2) && $past(tok_pid, 2) == PID_IN))
    else $error("answer without a transaction");
  chk_irq_cause: assert property (ep_irq != 3'h0 |-> $past(data_end) ||
      $past(hs_valid) || $past(tok_valid, 2))
    else $error("irq without a transaction");
  chk_irq_ep: assert property (ep_irq != 3'h0 |-> ep_irq == 3'h1 << cur_ep)
    else $error("irq on wrong endpoint");
  chk_hs_irq: assert property (resp_valid && resp_code inside {RESP_ACK,
      RESP_NAK, RESP_STALL} |-> ep_irq != 3'h0)
    else $error("handshake without irq");
  chk_tx_len: assert property (!(resp_valid && resp_code == RESP_TX_COUNT)
      |-> tx_len == 4'h0)
    else $error("length shown outside tx count");
  chk_bad_no_hs: assert property (data_end && (data_count > 5'h0A ||
      !data_checks_ok) |=> !resp_valid)
    else $error("handshake on invalid packet");
endmodule // ep_props

bind usb_endpoint_mode_responder ep_props u_props (.clk_sys, .rst_n, .psel,
  .penable, .pready, .pslverr, .tok_valid, .tok_pid, .tok_ep, .data_end,
  .data_count, .data_checks_ok, .hs_valid, .resp_valid, .resp_code, .tx_len,
  .ep_irq);

// ==== bench/host_model.sv ====
`timescale 1ns/1ns
module host_model
  import usb_ep_pkg::*;
(
  input  wire logic clk_sys,
  output logic       tok_valid,
  output pid_t       tok_pid,
  output logic [1:0] tok_ep,
  output logic       data_start,
  output logic       data_end,
  output logic [4:0] data_count,
  output logic       data_toggle,
  output logic       data_crc_ok,
  output logic       data_checks_ok,
  output logic       hs_valid,
  output logic       hs_ack
);
  // idle link: no pulses, packet fields carry no meaning
  initial begin
    {tok_valid, tok_ep, data_start, data_end, hs_valid, hs_ack} = '0;
    {data_count, data_toggle, data_crc_ok, data_checks_ok} = '0;
    tok_pid = PID_NONE;
  end
  // one token, then its data packet or our handshake after the design's data
  task automatic xfer(input pid_t p, input logic [1:0] ep, input logic [4:0] c,
                      input logic t, input logic ok, input logic hs);
    @(posedge clk_sys);
    tok_valid <= 1'b1;
    tok_pid <= p;
    tok_ep <= ep;
    @(posedge clk_sys);
    tok_valid <= 1'b0;
    tok_pid <= PID_NONE;
    tok_ep <= ~ep;
    @(posedge clk_sys);
    if (p == PID_IN) begin
      if (hs) begin
        repeat (2) @(posedge clk_sys);
        hs_valid <= 1'b1;
        hs_ack <= 1'b1;
        @(posedge clk_sys);
        hs_valid <= 1'b0;
        hs_ack <= 1'b0;
      end
    end else begin
      data_start <= 1'b1;
      @(posedge clk_sys);
      data_start <= 1'b0;
      repeat (2) @(posedge clk_sys);
      data_end <= 1'b1;
      {data_count, data_toggle, data_crc_ok, data_checks_ok} <= {c, t, ok, ok};
      @(posedge clk_sys);
      data_end <= 1'b0;
      // stale fields flipped so nothing can lean on a held value
      {data_count, data_toggle, data_crc_ok, data_checks_ok} <= ~{c, t, ok, ok};
    end
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // host_model

// ==== bench/usb_endpoint_mode_responder_test.sv ====
`timescale 1ns/1ns
module usb_endpoint_mode_responder_test
  import usb_ep_pkg::*;
;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        tok_valid, data_start, data_end, data_toggle, data_crc_ok;
  logic        data_checks_ok, hs_valid, hs_ack, resp_valid, tog;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  tok_ep;
  logic [4:0]  data_count, cnt;
  logic [3:0]  tx_len;
  logic [2:0]  ep_irq;
  pid_t        tok_pid;
  resp_t       resp_code;
  resp_t       in_tab[16];
  logic [32:0] exp_rd[$];
  logic [10:0] exp_ev[$];
  int          n_errors, check_count, k;

  usb_endpoint_mode_responder dut (.clk_sys, .rst_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .tok_valid, .tok_pid, .tok_ep,
    .data_start, .data_end, .data_count, .data_toggle, .data_crc_ok,
    .data_checks_ok, .hs_valid, .hs_ack, .resp_valid, .resp_code, .tx_len, .ep_irq);
  host_model host (.clk_sys, .tok_valid, .tok_pid, .tok_ep, .data_start, .data_end,
    .data_count, .data_toggle, .data_crc_ok, .data_checks_ok, .hs_valid, .hs_ack);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic cmp(input logic [32:0] e, input logic [32:0] a);
    check_count++;
    if (a !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  // monitor: every read and every answer or irq takes the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp(exp_rd.size() ? exp_rd.pop_front() : 'x, {pslverr, prdata});
    // outputs stay unknown until the first reset edge, so skip them in reset
    if (rst_n === 1'b1 && (resp_valid === 1'b1 || ep_irq !== 3'h0))
      cmp(exp_ev.size() ? 33'(exp_ev.pop_front()) : 'x,
          33'({resp_valid, resp_valid ? resp_code : 3'h0, tx_len, ep_irq}));
  end

  // master never assumes a latency; it waits on pready with a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clk_sys);
    if (n == 20)
      n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back({a > 8'h14, e});
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [10:0] ev(resp_t c, logic [3:0] l, logic [2:0] i);
    return {c != RESP_IGNORE, c, l, i};
  endfunction

  // notes the owed answers, then lets the host send the token
  task automatic xact(input pid_t p, input logic [1:0] ep, input logic [4:0] c,
                      input logic t, input logic ok, input logic [10:0] e1,
                      input logic [10:0] e2);
    if (e1 != 11'h0)
      exp_ev.push_back(e1);
    if (e2 != 11'h0)
      exp_ev.push_back(e2);
    host.xfer(p, ep, c, t, ok, e2 != 11'h0 && p == PID_IN);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: the whole sequence needs far fewer than 10000 cycles
  initial begin
    #400000;
    n_errors++;
    stop_test;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n = 1'b0;
    in_tab = '{RESP_IGNORE, RESP_NAK, RESP_STALL, RESP_STALL, RESP_IGNORE,
      RESP_IGNORE, RESP_TX_ZERO, RESP_TX_COUNT, RESP_IGNORE, RESP_IGNORE,
      RESP_TX_ZERO, RESP_TX_ZERO, RESP_NAK, RESP_TX_COUNT, RESP_NAK, RESP_TX_COUNT};
    void'($urandom(18));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (k = 0; k < 6; k++)
      rd(8'(k * 4), 32'h0);
    rd(8'h18, 32'h0);
    xact(PID_SETUP, 2'h1, 5'h0A, 1'b0, 1'b1, 11'h0, 11'h0);
    rd(8'h08, 32'h0);
    $display("test reset done");
    apb(1'b1, 8'h00, 32'h02);
    xact(PID_SETUP, 2'h0, 5'h0A, 1'b0, 1'b1, ev(RESP_ACK, 4'h0, 3'h1), 11'h0);
    apb(1'b1, 8'h00, 32'h0F);
    rd(8'h00, 32'h11);
    apb(1'b1, 8'h04, 32'h05);
    rd(8'h04, 32'h4A);
    apb(1'b1, 8'h00, 32'h0F);
    apb(1'b1, 8'h04, 32'h05);
    $display("test setup done");
    xact(PID_IN, 2'h0, 5'h0, 1'b0, 1'b1, ev(RESP_TX_COUNT, 4'h5, 3'h0),
         ev(RESP_IGNORE, 4'h0, 3'h1));
    rd(8'h00, 32'h5E);
    xact(PID_OUT, 2'h0, 5'h02, 1'b0, 1'b1, ev(RESP_STALL, 4'h0, 3'h1), 11'h0);
    rd(8'h00, 32'h7E);
    apb(1'b1, 8'h00, 32'h0F);
    xact(PID_OUT, 2'h0, 5'h02, 1'b1, 1'b1, ev(RESP_ACK, 4'h0, 3'h1), 11'h0);
    rd(8'h00, 32'h3E);
    xact(PID_OUT, 2'h0, 5'h02, 1'b1, 1'b1, ev(RESP_ACK, 4'h0, 3'h1), 11'h0);
    rd(8'h00, 32'h3E);
    $display("test status done");
    apb(1'b1, 8'h08, 32'h01);
    xact(PID_IN, 2'h1, 5'h0, 1'b0, 1'b1, ev(RESP_NAK, 4'h0, 3'h2), 11'h0);
    xact(PID_OUT, 2'h1, 5'h02, 1'b1, 1'b1, ev(RESP_NAK, 4'h0, 3'h2), 11'h0);
    rd(8'h08, 32'h61);
    apb(1'b1, 8'h0C, 32'h07);
    // every mode gets an in token, some only ignore it; iso in is left out, it has no handshake
    for (k = 0; k < 16; k++) begin
      if (k != 7) begin
        apb(1'b1, 8'h08, 32'(k));
        xact(PID_IN, 2'h1, 5'h0, 1'b0, 1'b1, ev(in_tab[k], in_tab[k] == RESP_TX_COUNT ?
          4'h7 : 4'h0, in_tab[k] inside {RESP_NAK, RESP_STALL} ? 3'h2 : 3'h0),
          in_tab[k] inside {RESP_TX_ZERO, RESP_TX_COUNT} ?
          ev(RESP_IGNORE, 4'h0, 3'h2) : 11'h0);
      end
    end
    $display("test in modes done");
    cnt = 5'(2 + $urandom % 9);
    tog = 1'($urandom);
    apb(1'b1, 8'h10, 32'h09);
    xact(PID_IN, 2'h2, 5'h0, 1'b0, 1'b1, 11'h0, 11'h0);
    xact(PID_OUT, 2'h2, cnt, tog, 1'b1, ev(RESP_ACK, 4'h0, 3'h4), 11'h0);
    rd(8'h10, 32'h38);
    rd(8'h14, 32'({tog, 1'b1, 2'b00, cnt[3:0]}));
    apb(1'b1, 8'h10, 32'h09);
    xact(PID_OUT, 2'h2, cnt, tog, 1'b0, ev(RESP_IGNORE, 4'h0, 3'h4), 11'h0);
    rd(8'h10, 32'h09);
    rd(8'h14, 32'({tog, 1'b0, 2'b00, cnt[3:0]}));
    // iso out takes the data silently: out bit and irq, no handshake
    apb(1'b1, 8'h10, 32'h05);
    xact(PID_OUT, 2'h2, cnt, tog, 1'b1, ev(RESP_IGNORE, 4'h0, 3'h4), 11'h0);
    rd(8'h10, 32'h25);
    apb(1'b1, 8'h00, 32'h02);
    xact(PID_SETUP, 2'h0, 5'h0B, 1'b0, 1'b1, ev(RESP_IGNORE, 4'h0, 3'h1), 11'h0);
    rd(8'h00, 32'h82);
    xact(PID_SETUP, 2'h0, 5'h0A, 1'b0, 1'b0, ev(RESP_IGNORE, 4'h0, 3'h1), 11'h0);
    $display("test invalid done");
    repeat (4) @(posedge clk_sys);
    cmp(33'(exp_rd.size() + exp_ev.size()), 33'h0);
    stop_test;
  end
endmodule // usb_endpoint_mode_responder_test
